// ---- inc/sensor_timers_defines.svh ----
// Constants for the sensing-domain timer group
`ifndef SENSOR_TIMERS_DEFINES_SVH
`define SENSOR_TIMERS_DEFINES_SVH

`define TMR_W 16
`define NUM_ST 2
`define NUM_CH 4
`define NUM_TICK 4

// Configuration item codes on the write ports
`define ITEM_ST_CTRL 4'h0
`define ITEM_ST_TGT 4'h2
`define ITEM_CC_CTRL 4'h4
`define ITEM_CC_TGT 4'h5
`define ITEM_CH_CTRL 4'h6
`define ITEM_CH_VAL 4'h8

// Simple timer control fields
`define ST_PERIODIC 0
`define ST_USE_TICK 1
`define ST_PRE_LSB 2
`define ST_PRE_MSB 5
`define ST_TSEL_LSB 6
`define ST_TSEL_MSB 7

// Capture/compare control fields
`define CC_PERIODIC 0
`define CC_CLK_LSB 1
`define CC_CLK_MSB 2
`define CC_ADC_LSB 3
`define CC_ADC_MSB 5
`define ADC_SEL_CC 3'h4

// Per-channel control fields, four bits per channel
`define CH_FIELDS 4
`define CH_CAPTURE 0
`define CH_PERIODIC 1
`define CH_FALL 2
`define CH_SET 3

// Reset values
`define ST_CTRL_RST 8'h00
`define TGT_RST 16'hffff
`define CC_CTRL_RST 6'h00
`define CH_CTRL_RST 16'h0000
`define CH_VAL_RST 16'h0000

`endif

// ---- inc/sensor_timers_pkg.sv ----
// Types shared by the sensing-domain timers
`include "sensor_timers_defines.svh"

package sensor_timers_pkg;
   typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_RUN = 2'b10} run_state_t;
   typedef enum logic [1:0] {CLK_24M = 2'h0, CLK_2M = 2'h1, CLK_32K = 2'h2} cc_clk_t;

   typedef struct packed {
      run_state_t state;
      logic [15:0] pre;
      logic tick_d;
      logic [`TMR_W-1:0] cnt;
      logic evt;
   } simple_state_t;

   typedef struct packed {
      logic [`NUM_TICK-1:0] tick_s1;
      logic [`NUM_TICK-1:0] tick_s2;
      logic [`NUM_CH-1:0] cap_s1;
      logic [`NUM_CH-1:0] cap_s2;
      logic [`NUM_CH-1:0] cap_d;
      logic [2:0] src_s1;
      logic [2:0] src_s2;
      logic src_d;
      logic [`NUM_ST-1:0][7:0] st_ctrl;
      logic [`NUM_ST-1:0][`TMR_W-1:0] st_tgt;
      logic [5:0] cc_ctrl;
      logic [`TMR_W-1:0] cc_tgt;
      logic [15:0] ch_ctrl;
      logic [`NUM_CH-1:0][`TMR_W-1:0] ch_val;
      run_state_t cc_state;
      logic [`TMR_W-1:0] cc_cnt;
      logic [`NUM_CH-1:0] armed;
      logic [`NUM_CH-1:0] wave;
      logic [`NUM_CH-1:0] ch_evt;
      logic cc_evt;
      logic adc_trig;
   } main_state_t;
endpackage

// ---- logic/simple_prescaled_timer.sv ----
// One simple 16-bit timer with power-of-two prescaler
`timescale 1ns/10ps
`include "sensor_timers_defines.svh"

module simple_prescaled_timer (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic start,
   input wire logic stop,
   input wire logic periodic,
   input wire logic use_tick,
   input wire logic [3:0] prescale_exp,
   input wire logic [`TMR_W-1:0] target,
   input wire logic tick_lvl,
   output logic [`TMR_W-1:0] count,
   output logic running,
   output logic expired
);
   sensor_timers_pkg::simple_state_t state_reg;
   sensor_timers_pkg::simple_state_t state_next;

   always_comb begin
      logic adv_src;
      logic [15:0] mask;
      adv_src = use_tick ? (tick_lvl ^ state_reg.tick_d) : 1'b1;
      mask = ~(16'hffff << prescale_exp);
      state_next = state_reg;
      state_next.evt = 1'b0;
      state_next.tick_d = tick_lvl;
      unique case (state_reg.state)
         sensor_timers_pkg::ST_IDLE: begin
            if (start && !stop) begin
               state_next.state = sensor_timers_pkg::ST_RUN;
               state_next.cnt = '0;
               state_next.pre = '0;
            end
         end
         sensor_timers_pkg::ST_RUN: begin
            if (stop) begin
               state_next.state = sensor_timers_pkg::ST_IDLE;
            end else if (start) begin
               state_next.cnt = '0;
               state_next.pre = '0;
            end else if (adv_src) begin
               if ((state_reg.pre & mask) == mask) begin
                  state_next.pre = '0;
                  if (state_reg.cnt == target) begin
                     state_next.evt = 1'b1;
                     state_next.cnt = '0;
                     if (!periodic) begin
                        state_next.state = sensor_timers_pkg::ST_IDLE;
                     end
                  end else begin
                     state_next.cnt = state_reg.cnt + 16'h1;
                  end
               end else begin
                  state_next.pre = state_reg.pre + 16'h1;
               end
            end
         end
         default: state_next.state = sensor_timers_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= '{state: sensor_timers_pkg::ST_IDLE, default: '0};
      end else begin
         state_reg <= state_next;
      end
   end

   assign count = state_reg.cnt;
   assign running = (state_reg.state == sensor_timers_pkg::ST_RUN);
   assign expired = state_reg.evt;

   ////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_oneshot_expiry;
      expired && !periodic;
   endsequence

   property p_oneshot_stop;
      s_oneshot_expiry |-> !running ##1 (!running || $past(start));
   endproperty
   a_oneshot_stop: assert property (p_oneshot_stop) else $error("one-shot kept running");

   property p_periodic_reload;
      expired && periodic |-> running && count == 16'h0;
   endproperty
   a_periodic_reload: assert property (p_periodic_reload) else $error("no reload");

   property p_single_pulse;
      expired && target != 16'h0 |=> !expired;
   endproperty
   a_single_pulse: assert property (p_single_pulse) else $error("event too long");

   property p_start_clears;
      start && !stop |=> running && count == 16'h0;
   endproperty
   a_start_clears: assert property (p_start_clears) else $error("start failed");

   property p_div1_step;
      running && !use_tick && prescale_exp == 4'h0 && !start && !stop && count != target
         |=> count == 16'($past(count) + 16'h1);
   endproperty
   a_div1_step: assert property (p_div1_step) else $error("count did not step");

   property p_tick_hold;
      running && use_tick && tick_lvl == state_reg.tick_d && !start && !stop |=> $stable(count);
   endproperty
   a_tick_hold: assert property (p_tick_hold) else $error("advance without edge");
endmodule

// ---- logic/sensor_domain_timers.sv ----
// Sensing-domain timer group: two simple timers and one capture/compare timer
`timescale 1ns/10ps
`include "sensor_timers_defines.svh"

module sensor_domain_timers (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [2:0] scp_start,
   input wire logic [2:0] scp_stop,
   input wire logic scp_cfg_we,
   input wire logic [3:0] scp_cfg_item,
   input wire logic [15:0] scp_cfg_data,
   input wire logic [2:0] app_start,
   input wire logic [2:0] app_stop,
   input wire logic app_cfg_we,
   input wire logic [3:0] app_cfg_item,
   input wire logic [15:0] app_cfg_data,
   input wire logic [`NUM_TICK-1:0] tick_in,
   input wire logic [`NUM_CH-1:0] cap_in,
   input wire logic src_24m,
   input wire logic src_2m,
   input wire logic src_32k,
   output logic [`NUM_ST-1:0][`TMR_W-1:0] st_count,
   output logic [`NUM_ST-1:0] st_running,
   output logic [`NUM_ST-1:0] st_evt,
   output logic [`TMR_W-1:0] cc_count,
   output logic cc_running,
   output logic cc_evt,
   output logic [`NUM_CH-1:0] ch_evt,
   output logic [`NUM_CH-1:0][`TMR_W-1:0] ch_value,
   output logic [`NUM_CH-1:0] wave_out,
   output logic adc_trig
);
   logic [1:0] rst_sync;
   logic rst_n;
   logic [2:0] start_any;
   logic [2:0] stop_any;
   sensor_timers_pkg::main_state_t state_reg;
   sensor_timers_pkg::main_state_t state_next;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_sync <= 2'b00;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   // Both processors drive the same controls and see the same status
   assign start_any = scp_start | app_start;
   assign stop_any = scp_stop | app_stop;

   ////////////////////////////////////////////////////////////////////////////
   function automatic sensor_timers_pkg::main_state_t cfg_write(
      sensor_timers_pkg::main_state_t s, logic [3:0] item, logic [15:0] d);
      sensor_timers_pkg::main_state_t o;
      o = s;
      if (item == `ITEM_CC_CTRL) begin
         o.cc_ctrl = d[5:0];
      end else if (item == `ITEM_CC_TGT) begin
         o.cc_tgt = d;
      end else if (item == `ITEM_CH_CTRL) begin
         o.ch_ctrl = d;
      end else if (item[3:1] == 3'(`ITEM_ST_CTRL >> 1)) begin
         o.st_ctrl[item[0]] = d[7:0];
      end else if (item[3:1] == 3'(`ITEM_ST_TGT >> 1)) begin
         o.st_tgt[item[0]] = d;
      end else if (item[3:2] == 2'(`ITEM_CH_VAL >> 2)) begin
         o.ch_val[item[1:0]] = d;
      end
      return o;
   endfunction

   always_comb begin
      logic sel_src;
      logic cc_adv;
      logic [2:0] adc_sel;
      logic [3:0] cfg;
      state_next = state_reg;
      sel_src = 1'b0;
      cc_adv = 1'b0;
      adc_sel = state_reg.cc_ctrl[`CC_ADC_MSB:`CC_ADC_LSB];
      cfg = 4'h0;
      state_next.tick_s1 = tick_in;
      state_next.tick_s2 = state_reg.tick_s1;
      state_next.cap_s1 = cap_in;
      state_next.cap_s2 = state_reg.cap_s1;
      state_next.cap_d = state_reg.cap_s2;
      state_next.src_s1 = {src_32k, src_2m, src_24m};
      state_next.src_s2 = state_reg.src_s1;
      state_next.ch_evt = '0;
      state_next.cc_evt = 1'b0;
      // Application port wins when both write in the same cycle
      if (scp_cfg_we) begin
         state_next = cfg_write(state_next, scp_cfg_item, scp_cfg_data);
      end
      if (app_cfg_we) begin
         state_next = cfg_write(state_next, app_cfg_item, app_cfg_data);
      end
      // Sources are sampled, so only edges slower than clk/2 count; the
      // fastest source therefore runs at best at half the system clock
      case (state_reg.cc_ctrl[`CC_CLK_MSB:`CC_CLK_LSB])
         sensor_timers_pkg::CLK_24M: sel_src = state_reg.src_s2[0];
         sensor_timers_pkg::CLK_2M: sel_src = state_reg.src_s2[1];
         default: sel_src = state_reg.src_s2[2];
      endcase
      state_next.src_d = sel_src;
      cc_adv = sel_src & ~state_reg.src_d;
      unique case (state_reg.cc_state)
         sensor_timers_pkg::ST_IDLE: begin
            if (start_any[2] && !stop_any[2]) begin
               state_next.cc_state = sensor_timers_pkg::ST_RUN;
               state_next.cc_cnt = '0;
               state_next.armed = '1;
               state_next.wave = '0;
            end
         end
         sensor_timers_pkg::ST_RUN: begin
            if (stop_any[2]) begin
               state_next.cc_state = sensor_timers_pkg::ST_IDLE;
            end else if (start_any[2]) begin
               state_next.cc_cnt = '0;
               state_next.armed = '1;
               state_next.wave = '0;
            end else begin
               if (cc_adv) begin
                  if (state_reg.cc_cnt == state_reg.cc_tgt) begin
                     state_next.cc_evt = 1'b1;
                     state_next.cc_cnt = '0;
                     if (!state_reg.cc_ctrl[`CC_PERIODIC]) begin
                        state_next.cc_state = sensor_timers_pkg::ST_IDLE;
                     end
                  end else begin
                     state_next.cc_cnt = state_reg.cc_cnt + 16'h1;
                  end
               end
               for (int i = 0; i < `NUM_CH; i++) begin
                  cfg = state_reg.ch_ctrl[i*`CH_FIELDS +: `CH_FIELDS];
                  // Set-mode outputs drop at the period end to form PWM
                  if (cc_adv && state_reg.cc_cnt == state_reg.cc_tgt && cfg[`CH_SET]) begin
                     state_next.wave[i] = 1'b0;
                  end
                  if (state_reg.armed[i] && !cfg[`CH_CAPTURE] && cc_adv &&
                      state_reg.cc_cnt == state_reg.ch_val[i]) begin
                     state_next.ch_evt[i] = 1'b1;
                     state_next.wave[i] = cfg[`CH_SET] ? 1'b1 : ~state_reg.wave[i];
                     state_next.armed[i] = cfg[`CH_PERIODIC];
                  end
                  if (state_reg.armed[i] && cfg[`CH_CAPTURE] &&
                      (cfg[`CH_FALL] ? (~state_reg.cap_s2[i] & state_reg.cap_d[i])
                                     : (state_reg.cap_s2[i] & ~state_reg.cap_d[i]))) begin
                     // Capture beats a processor write of the same register
                     state_next.ch_val[i] = state_reg.cc_cnt;
                     state_next.ch_evt[i] = 1'b1;
                     state_next.armed[i] = cfg[`CH_PERIODIC];
                  end
               end
            end
         end
         default: state_next.cc_state = sensor_timers_pkg::ST_IDLE;
      endcase
      if (adc_sel == `ADC_SEL_CC) begin
         state_next.adc_trig = state_next.cc_evt;
      end else if (adc_sel < `ADC_SEL_CC) begin
         state_next.adc_trig = state_next.ch_evt[adc_sel[1:0]];
      end else begin
         state_next.adc_trig = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= '{st_ctrl: {`NUM_ST{`ST_CTRL_RST}}, st_tgt: {`NUM_ST{`TGT_RST}},
                        cc_ctrl: `CC_CTRL_RST, cc_tgt: `TGT_RST, ch_ctrl: `CH_CTRL_RST,
                        ch_val: {`NUM_CH{`CH_VAL_RST}}, cc_state: sensor_timers_pkg::ST_IDLE,
                        default: '0};
      end else begin
         state_reg <= state_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   for (genvar g = 0; g < `NUM_ST; g++) begin : g_st
      simple_prescaled_timer u_st (
         .clk(clk),
         .rst_n(rst_n),
         .start(start_any[g]),
         .stop(stop_any[g]),
         .periodic(state_reg.st_ctrl[g][`ST_PERIODIC]),
         .use_tick(state_reg.st_ctrl[g][`ST_USE_TICK]),
         .prescale_exp(state_reg.st_ctrl[g][`ST_PRE_MSB:`ST_PRE_LSB]),
         .target(state_reg.st_tgt[g]),
         .tick_lvl(state_reg.tick_s2[state_reg.st_ctrl[g][`ST_TSEL_MSB:`ST_TSEL_LSB]]),
         .count(st_count[g]),
         .running(st_running[g]),
         .expired(st_evt[g])
      );
   end

   assign cc_count = state_reg.cc_cnt;
   assign cc_running = (state_reg.cc_state == sensor_timers_pkg::ST_RUN);
   assign cc_evt = state_reg.cc_evt;
   assign ch_evt = state_reg.ch_evt;
   assign ch_value = state_reg.ch_val;
   assign wave_out = state_reg.wave;
   assign adc_trig = state_reg.adc_trig;

   ////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_cc_oneshot_end;
      cc_evt && !state_reg.cc_ctrl[`CC_PERIODIC] && $stable(state_reg.cc_ctrl);
   endsequence

   property p_cc_oneshot;
      s_cc_oneshot_end |-> !cc_running && cc_count == 16'h0;
   endproperty
   a_cc_oneshot: assert property (p_cc_oneshot) else $error("cc one-shot kept running");

   property p_cc_start;
      start_any[2] && !stop_any[2] |=> cc_running && cc_count == 16'h0 && wave_out == 4'h0;
   endproperty
   a_cc_start: assert property (p_cc_start) else $error("cc start failed");

   sequence s_cap2_edge;
      cc_running && state_reg.armed[2] && state_reg.ch_ctrl[2*`CH_FIELDS + `CH_CAPTURE] &&
         !state_reg.ch_ctrl[2*`CH_FIELDS + `CH_FALL] && !start_any[2] && !stop_any[2] &&
         state_reg.cap_s2[2] && !state_reg.cap_d[2];
   endsequence

   property p_capture2;
      s_cap2_edge |=> ch_value[2] == $past(state_reg.cc_cnt) && ch_evt[2];
   endproperty
   a_capture2: assert property (p_capture2) else $error("capture missed");

   property p_set0;
      ch_evt[0] && $stable(state_reg.ch_ctrl) && state_reg.ch_ctrl[`CH_SET] &&
         !state_reg.ch_ctrl[`CH_CAPTURE] |-> wave_out[0];
   endproperty
   a_set0: assert property (p_set0) else $error("set output low");

   property p_toggle1;
      ch_evt[1] && $stable(state_reg.ch_ctrl) && !state_reg.ch_ctrl[`CH_FIELDS + `CH_SET] &&
         !state_reg.ch_ctrl[`CH_FIELDS + `CH_CAPTURE] |-> wave_out[1] != $past(wave_out[1]);
   endproperty
   a_toggle1: assert property (p_toggle1) else $error("toggle missed");

   property p_adc_cc;
      $stable(state_reg.cc_ctrl) && state_reg.cc_ctrl[`CC_ADC_MSB:`CC_ADC_LSB] == `ADC_SEL_CC
         |-> adc_trig == cc_evt;
   endproperty
   a_adc_cc: assert property (p_adc_cc) else $error("converter trigger wrong");
endmodule

// ---- verif/conv_start_sink.sv ----
// Converter-side model: counts conversion starts from the timer trigger
`timescale 1ns/10ps

module conv_start_sink (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic trig,
   output logic [15:0] starts
);
   ////////////////////////////////////////////////////////////////////////////////
   // Any single-cycle trigger pulse starts one conversion
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         starts <= 16'h0000;
      end else if (trig) begin
         starts <= starts + 16'h0001;
      end
   end
endmodule

// ---- verif/tb_top.sv ----
// Self-checking bench for the sensing-domain timer group
`timescale 1ns/10ps
`include "sensor_timers_defines.svh"

module tb_top;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic [2:0] scp_start = 3'h0, scp_stop = 3'h0, app_start = 3'h0, app_stop = 3'h0;
   logic scp_cfg_we = 1'b0, app_cfg_we = 1'b0;
   logic [3:0] scp_cfg_item = 4'h0, app_cfg_item = 4'h0;
   logic [15:0] scp_cfg_data = 16'h0000, app_cfg_data = 16'h0000;
   logic [`NUM_TICK-1:0] tick_in = 4'h0;
   logic [`NUM_CH-1:0] cap_in = 4'h0;
   logic src_24m = 1'b0, src_2m = 1'b0, src_32k = 1'b0;
   logic [`NUM_ST-1:0][`TMR_W-1:0] st_count;
   logic [`NUM_ST-1:0] st_running, st_evt;
   logic [`TMR_W-1:0] cc_count;
   logic cc_running, cc_evt, adc_trig;
   logic [`NUM_CH-1:0] ch_evt, wave_out, prev_w;
   logic [`NUM_CH-1:0][`TMR_W-1:0] ch_value;
   logic [15:0] starts, base;
   integer seed = 32'hccec8fce;
   int err_total = 0, check_count = 0, cyc = 0, tcyc = 0, last0 = 0, gap0 = 0;
   int n_st0, n_st1, n_cc, n_w0, n_w1, t, e, k;
   int n_ch [4];
   logic cap_ok;
   logic [15:0] tt, v0, v1, v3;

   sensor_domain_timers u_dut (.clk(clk), .arst_n(arst_n), .scp_start(scp_start),
      .scp_stop(scp_stop), .scp_cfg_we(scp_cfg_we), .scp_cfg_item(scp_cfg_item),
      .scp_cfg_data(scp_cfg_data), .app_start(app_start), .app_stop(app_stop),
      .app_cfg_we(app_cfg_we), .app_cfg_item(app_cfg_item), .app_cfg_data(app_cfg_data),
      .tick_in(tick_in), .cap_in(cap_in), .src_24m(src_24m), .src_2m(src_2m),
      .src_32k(src_32k), .st_count(st_count), .st_running(st_running), .st_evt(st_evt),
      .cc_count(cc_count), .cc_running(cc_running), .cc_evt(cc_evt), .ch_evt(ch_evt),
      .ch_value(ch_value), .wave_out(wave_out), .adc_trig(adc_trig));

   conv_start_sink u_sink (.clk(clk), .rst_n(arst_n), .trig(adc_trig), .starts(starts));

   always #50 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////////////
   // Slow clock sources; the fast one is noise, it cannot be tracked at 10 MHz
   always begin
      @(posedge clk);
      #2;
      cyc++;
      src_24m = 1'($random(seed));
      if (cyc % 10 == 0) src_2m = ~src_2m;
      if (cyc % 40 == 0) src_32k = ~src_32k;
      if (cyc == 20000) begin
         err_total++;
         $display("mismatch at %0t: run did not finish", $time);
         wrap_up();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Event monitor
   always @(posedge clk) begin
      tcyc++;
      if (st_evt[0] === 1'b1) begin
         n_st0++;
         gap0 = tcyc - last0;
         last0 = tcyc;
      end
      if (st_evt[1] === 1'b1) n_st1++;
      if (cc_evt === 1'b1) n_cc++;
      for (int i = 0; i < 4; i++) if (ch_evt[i] === 1'b1) n_ch[i]++;
      if (wave_out[0] === 1'b1 && prev_w[0] === 1'b0) n_w0++;
      if (wave_out[1] !== prev_w[1]) n_w1++;
      prev_w = wave_out;
      // Count may step on the capture edge itself
      if (ch_evt[2] === 1'b1) cap_ok = (ch_value[2] === cc_count) ||
         (ch_value[2] + 16'h0001 === cc_count) || (cc_count === 16'h0000 && ch_value[2] === tt);
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic clr();
      n_st0 = 0; n_st1 = 0; n_cc = 0; n_w0 = 0; n_w1 = 0;
      for (int i = 0; i < 4; i++) n_ch[i] = 0;
      cap_ok = 1'b0;
   endtask

   task automatic cfg(input bit app, input logic [3:0] item, input logic [15:0] data);
      if (app) begin
         app_cfg_we = 1'b1; app_cfg_item = item; app_cfg_data = data;
      end else begin
         scp_cfg_we = 1'b1; scp_cfg_item = item; scp_cfg_data = data;
      end
      @(posedge clk);
      #2;
      app_cfg_we = 1'b0;
      scp_cfg_we = 1'b0;
      // Idle edge, so back-to-back writes never re-raise a strobe in one step
      @(posedge clk);
      #2;
   endtask

   // Start or stop pulse on one port; returns just after the taking edge
   task automatic pulse(input bit app, input bit stp, input logic [2:0] m);
      if (stp) begin
         if (app) app_stop = m; else scp_stop = m;
      end else begin
         if (app) app_start = m; else scp_start = m;
      end
      @(posedge clk);
      #2;
      {app_start, app_stop, scp_start, scp_stop} = 12'h000;
   endtask

   task automatic wait_cnt(ref int c, input int n);
      int w;
      w = 0;
      while (c < n && w < 3000) begin
         @(posedge clk);
         w++;
      end
      #2;
      if (w == 3000) begin
         err_total++;
         $display("mismatch at %0t: event wait ran out", $time);
      end
   endtask

   function automatic int st_period(input int tg, input int ex);
      return (tg + 1) << ex;
   endfunction

   task automatic wrap_up();
      $display("checks %0d, mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (8) @(posedge clk);
      #2;
      arst_n = 1'b1;
      repeat (3) @(posedge clk);
      #2;
      check({st_running, cc_running, wave_out, cc_count}, 32'h0);
      // Periodic simple timer 0 from both ports, random prescale and target
      for (k = 0; k < 4; k++) begin
         e = $random(seed) & 3;
         t = ($random(seed) & 7) + 2;
         cfg(k[0], `ITEM_ST_TGT, 16'(t));
         cfg(~k[0], `ITEM_ST_CTRL, 16'(8'h01 | (e << 2)));
         pulse(k[0], 1'b0, 3'b001);
         check({st_running[0], st_count[0]}, 32'h10000);
         clr();
         wait_cnt(n_st0, 2);
         check(gap0, st_period(t, e));
         pulse(~k[0], 1'b1, 3'b001);
      end
      // One-shot simple timer 1 from the application port
      cfg(1'b1, 4'(`ITEM_ST_TGT + 1), 16'h0004);
      cfg(1'b1, 4'(`ITEM_ST_CTRL + 1), 16'h0000);
      clr();
      pulse(1'b1, 1'b0, 3'b010);
      repeat (20) @(posedge clk);
      #2;
      check(n_st1, 1);
      check(st_running[1], 1'b0);
      check(st_count[1], 16'h0000);
      // Stop wins over a start on the other port in the same cycle
      scp_start = 3'b010;
      pulse(1'b1, 1'b1, 3'b010);
      check(st_running[1], 1'b0);
      // Tick mode on source 2, others toggle as noise
      cfg(1'b0, `ITEM_ST_TGT, 16'h0003);
      cfg(1'b0, `ITEM_ST_CTRL, 16'h0083);
      pulse(1'b0, 1'b0, 3'b001);
      clr();
      repeat (8) begin
         repeat (5) @(posedge clk);
         #2;
         tick_in = {tick_in[3] ^ 1'($random(seed)), ~tick_in[2], 2'($random(seed))};
      end
      repeat (10) @(posedge clk);
      #2;
      check(n_st0, 2);
      pulse(1'b0, 1'b1, 3'b001);
      // Capture/compare timer on the 2 MHz source, trigger on its expiry
      tt = 16'(($random(seed) & 3) + 5);
      v0 = 16'((($random(seed) & 32'h7fffffff) % (tt - 1)) + 1);
      v1 = 16'((($random(seed) & 32'h7fffffff) % (tt - 1)) + 1);
      v3 = 16'((($random(seed) & 32'h7fffffff) % (tt - 1)) + 1);
      cfg(1'b0, `ITEM_CC_TGT, tt);
      cfg(1'b1, `ITEM_CC_CTRL, 16'h0023);
      cfg(1'b0, `ITEM_CH_CTRL, 16'h032a);
      cfg(1'b1, `ITEM_CH_VAL, v0);
      cfg(1'b0, 4'(`ITEM_CH_VAL + 1), v1);
      cfg(1'b1, 4'(`ITEM_CH_VAL + 3), v3);
      base = starts;
      pulse(1'b0, 1'b0, 3'b100);
      check({cc_running, cc_count}, 32'h10000);
      clr();
      repeat (50) @(posedge clk);
      #2;
      cap_in[2] = 1'b1;
      repeat (4) @(posedge clk);
      #2;
      cap_in[2] = 1'b0;
      wait_cnt(n_cc, 2);
      check(n_ch[0], 2);
      check(n_w1, 2);
      check(n_w0, 2);
      check(n_ch[3], 1);
      check(n_ch[2], 1);
      check(cap_ok, 1'b1);
      check(ch_value[0], v0);
      check(starts - base, 16'h0002);
      pulse(1'b1, 1'b1, 3'b100);
      check(cc_running, 1'b0);
      // One-shot capture/compare run must stop itself after one expiry
      cfg(1'b1, `ITEM_CC_CTRL, 16'h0022);
      clr();
      pulse(1'b0, 1'b0, 3'b100);
      wait_cnt(n_cc, 1);
      repeat (30) @(posedge clk);
      #2;
      check(n_cc, 1);
      check(cc_running, 1'b0);
      check(cc_count, 16'h0000);
      wrap_up();
   end
endmodule
